// ### core/posrc_pkg.sv
// Constants and types for the power-off and sleep request controller.
// Assumes a 125 MHz APB clock; pins arrive synchronous to that clock.
package posrc_pkg;

  // Clock period and one millisecond, both in ns
  localparam int CLK_NS = 8;
  localparam int SEC_NS = 1_000_000;
  localparam int SEC_US_MUL = 1_000;
  // Clock cycles in one second (rounded down)
  localparam int TICK_CYCLES = (SEC_NS / CLK_NS) * SEC_US_MUL;
  // Length of one power sequence in cycles
  localparam int SEQ_CYCLES = 32;
  // Default long-press time of the power button in seconds
  localparam int LONG_PRESS_SEC = 4;

  // Widths
  localparam int NRES = 8;                    // Managed resources
  localparam int NSRC = 7;                    // OFF request sources
  localparam int AW = 8;                      // APB address width

  // Register byte offsets
  localparam logic [7:0] A_CFG  = 8'h00;      // power_unit_config_reg
  localparam logic [7:0] A_RSEL = 8'h04;      // restart_select_reg
  localparam logic [7:0] A_RLVL = 8'h08;      // Reset level select
  localparam logic [7:0] A_WDG  = 8'h0c;      // Watchdog control
  localparam logic [7:0] A_ASLP = 8'h10;      // Sleep pin assignment
  localparam logic [7:0] A_AENA = 8'h14;      // Enable A assignment
  localparam logic [7:0] A_AENB = 8'h18;      // Enable B assignment
  localparam logic [7:0] A_KEEP = 8'h1c;      // Regulator sleep mode
  localparam logic [7:0] A_STAT = 8'h20;      // State and pending

  // Config register fields
  localparam int F_DLY    = 0;                // switch_off_delay, 2 bits
  localparam int F_POL    = 2;                // Sleep pin active high
  localparam int F_UNMASK = 3;                // Sleep pin unmasked
  localparam int F_SW_ON  = 4;                // software_on_bit
  localparam int F_SOFTWARE_RESET_BIT = 5;                // software_reset_bit

  // Watchdog register fields
  localparam int F_WD_EN   = 0;               // Enable
  localparam int F_WD_LOCK = 1;               // Write lock
  localparam int F_WD_KICK = 2;               // Restart count
  localparam int F_WD_TO   = 8;               // Timeout seconds, 8 bits

  // OFF source indices
  localparam int SRC_BUTTON = 0;
  localparam int SRC_PDOWN  = 1;
  localparam int SRC_WDOG   = 2;
  localparam int SRC_THERM  = 3;
  localparam int SRC_SWRST  = 4;
  localparam int SRC_VLOW   = 5;
  localparam int SRC_ADC    = 6;
  // Sources that wait for the switch-off delay
  localparam logic [6:0] DELAYED_MASK = 7'h47;

  // Reset values
  localparam logic [6:0] RSEL_RST = 7'h00;    // All shut down
  localparam logic [6:0] RLVL_RST = 7'h7f;    // All hardware level
  localparam logic [7:0] WDTO_RST = 8'h10;    // Watchdog timeout
  localparam logic [7:0] ASG_RST  = 8'h00;    // Nothing assigned
  localparam logic [7:0] KEEP_RST = 8'h00;    // None forced on in sleep

  // Delay code to seconds: 0, 1, 2, 4
  localparam logic [2:0] DLY_SEC [0:3] = '{3'h0, 3'h1, 3'h2, 3'h4};

  // Power state machine
  typedef enum logic [2:0] {
    S_OFF, S_OFF_TO_ACTIVE_SEQ, S_ACTIVE, S_ACTIVE_TO_SLEEP_SEQ,
    S_SLEEP, S_SLEEP_TO_ACTIVE_SEQ, S_ACTIVE_TO_OFF_SEQ, S_SLEEP_TO_OFF_SEQ
  } posrc_state_t;

endpackage

// ### core/posrc_sync.sv
// Two-stage synchroniser for a group of slow external pins.
// Assumes pins change far slower than the clock.
`timescale 1ns/1ns
module posrc_sync #(
  parameter int W = 1                         // Number of pins
) (
  input  wire logic         pclk,             // System clock
  input  wire logic         presetn,          // Async reset, low
  input  wire logic [W-1:0] d,                // Raw pin levels
  output logic      [W-1:0] q                 // Synchronised levels
);

  logic [W-1:0] meta;                         // First stage only

  // Two flops in a row, first read by second only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;                              // R19
      q    <= meta;
    end
  end

  // Output follows the pin two clocks later
  a_sync_lag: assert property (@(posedge pclk) disable iff (!presetn) // R19
    $past(presetn, 2) |-> q == $past(d, 2))
    else $error("sync lag wrong");

endmodule

// ### core/posrc_top.sv
// Power-off, sleep and wake request controller with APB registers.
// Assumes APB master on pclk and pins synchronous to pclk.
// Operation
// [R01] One switch-off delay 0/1/2/4 s shared
// [R02] Each OFF request picks hardware or software reset
// [R03] Restart select chooses shutdown or cold restart
// [R04] Shutdown runs matching off sequence, stays off
// [R05] Cold restart powers up again unless gated
// [R06] Watchdog off at reset, lockable, timeout is OFF
// [R07] On-bit and hold pin both released turn off
// [R08] Sleep request moves ACTIVE to SLEEP
// [R09] Per-resource register sets its sleep mode
// [R10] Pending unmasked interrupt blocks entering sleep
// [R11] Only interrupt or sleep pin wakes
// [R12] Wake acts only in SLEEP
// [R13] Sleep-pin resources switch only with sequences
// [R14] Enable-pin resources switch immediately
// [R15] Any resource assignable to any pin mix
// [R16] OFF requests win over sleep and ON
// [R17] New ON only after OFF request removed
// [R18] Sleep pin active low by default, configurable
// [R19] External pins synchronised before use
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
module posrc_top #(
  parameter int TICK_CYCLES  = posrc_pkg::TICK_CYCLES,    // Cycles per s
  parameter int LONG_PRESS_S = posrc_pkg::LONG_PRESS_SEC  // Button hold
) (
  input  wire logic        pclk,              // Clock, 125 MHz
  input  wire logic        presetn,           // Async reset, low
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB write
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error
  input  wire logic        power_button_pin_n,   // Button, low pressed
  input  wire logic        power_down_pin,    // Power down, high
  input  wire logic        hold_on_pin,       // Hold on, high
  input  wire logic        sleep_control_pin, // Sleep request pin
  input  wire logic        direct_enable_a,   // Enable A, high
  input  wire logic        direct_enable_b,   // Enable B, high
  input  wire logic        thermal_event,     // Thermal shutdown
  input  wire logic        supply_low_event,  // Supply too low
  input  wire logic        adc_threshold_off_event, // ADC limit
  input  wire logic        irq_pending,       // Unmasked irq pending
  input  wire logic        on_request,        // Any ON request
  input  wire logic        on_gate,           // ON gating present
  output logic      [2:0]  power_state,       // Current state
  output logic             hw_reset_pulse,    // Hardware level reset
  output logic             sw_reset_pulse,    // Software level reset
  output logic      [7:0]  res_on             // Resource active
);

  typedef posrc_pkg::posrc_state_t posrc_st_t;

  posrc_st_t   state;                         // Power state
  posrc_st_t   next_state;                    // Its next value
  logic [5:0]  pin_s;                         // Synchronised pins
  logic [26:0] tick_cnt;                      // Second divider
  logic [3:0]  lp_sec;                        // Button held seconds
  logic [7:0]  wd_sec;                        // Watchdog seconds
  logic [6:0]  pend;                          // Latched OFF sources
  logic        keep_d;                        // Last on-keep level
  logic        keep_rel;                      // On-keep was released
  logic        dly_run;                       // Delay running
  logic [2:0]  dly_left;                      // Seconds remaining
  logic [4:0]  seq_cnt;                       // Sequence step count
  logic        cold_pend;                     // Restart after off
  // Software registers
  logic [1:0]  dly_code;                      // Switch-off delay
  logic        slp_pol;                       // Sleep pin polarity
  logic        slp_unmask;                    // Sleep pin unmask
  logic        sw_on;                         // Software on bit
  logic [6:0]  rsel;                          // 1 = cold restart
  logic [6:0]  rlvl;                          // 1 = hardware level
  logic        wd_en;                         // Watchdog enable
  logic        wd_lock;                       // Watchdog locked
  logic [7:0]  wd_to;                         // Watchdog timeout
  logic [7:0]  aslp;                          // Sleep pin assigned
  logic [7:0]  aena;                          // Enable A assigned
  logic [7:0]  aenb;                          // Enable B assigned
  logic [7:0]  keep;                          // On during sleep

  // Pins pass the synchroniser first
  posrc_sync #(.W(6)) u_sync (              // R19
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({direct_enable_b, direct_enable_a, sleep_control_pin,
               hold_on_pin, power_down_pin, power_button_pin_n}),
    .q       (pin_s)
  );

  // APB decode
  wire wr      = psel & penable & pwrite;     // Write strobe
  wire rd_set  = psel & ~penable;             // Setup phase
  wire hit_cfg = paddr == posrc_pkg::A_CFG;
  wire hit_rs  = paddr == posrc_pkg::A_RSEL;
  wire hit_rl  = paddr == posrc_pkg::A_RLVL;
  wire hit_wd  = paddr == posrc_pkg::A_WDG;
  wire hit_as  = paddr == posrc_pkg::A_ASLP;
  wire hit_aa  = paddr == posrc_pkg::A_AENA;
  wire hit_ab  = paddr == posrc_pkg::A_AENB;
  wire hit_kp  = paddr == posrc_pkg::A_KEEP;
  wire hit_st  = paddr == posrc_pkg::A_STAT;
  wire hit     = hit_cfg | hit_rs | hit_rl | hit_wd | hit_as
               | hit_aa | hit_ab | hit_kp | hit_st;
  wire wr_wd   = wr & hit_wd;                 // Watchdog write
  wire wd_kick = wr_wd & pwdata[posrc_pkg::F_WD_KICK];
  wire software_reset_bit  = wr & hit_cfg & pwdata[posrc_pkg::F_SOFTWARE_RESET_BIT];

  assign pready  = 1'b1;                      // Zero wait states
  assign pslverr = psel & penable & ~hit;     // Unmapped address

  // Read data selection
  wire [31:0] rd_val =
      hit_cfg ? {26'h0, 1'b0, sw_on, slp_unmask, slp_pol, dly_code} :
      hit_rs  ? {25'h0, rsel} :
      hit_rl  ? {25'h0, rlvl} :
      hit_wd  ? {16'h0, wd_to, 5'h0, 1'b0, wd_lock, wd_en} :
      hit_as  ? {24'h0, aslp} :
      hit_aa  ? {24'h0, aena} :
      hit_ab  ? {24'h0, aenb} :
      hit_kp  ? {24'h0, keep} :
      hit_st  ? {21'h0, cold_pend, pend, state} : 32'h0;

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (rd_set) prdata <= rd_val;
  end

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_code <= 2'h0;
      slp_pol <= 1'b0;                        // R18
      slp_unmask <= 1'b0;
      sw_on <= 1'b0;
    end else if (wr & hit_cfg) begin
      dly_code <= pwdata[posrc_pkg::F_DLY +: 2]; // R01
      slp_pol <= pwdata[posrc_pkg::F_POL];    // R18
      slp_unmask <= pwdata[posrc_pkg::F_UNMASK];
      sw_on <= pwdata[posrc_pkg::F_SW_ON];
    end
  end

  // Per-source selects and resource tables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsel <= posrc_pkg::RSEL_RST;
      rlvl <= posrc_pkg::RLVL_RST;
      aslp <= posrc_pkg::ASG_RST;
      aena <= posrc_pkg::ASG_RST;
      aenb <= posrc_pkg::ASG_RST;
      keep <= posrc_pkg::KEEP_RST;
    end else if (wr) begin
      if (hit_rs) rsel <= pwdata[6:0];        // R03
      if (hit_rl) rlvl <= pwdata[6:0];        // R02
      if (hit_as) aslp <= pwdata[7:0];        // R15
      if (hit_aa) aena <= pwdata[7:0];        // R15
      if (hit_ab) aenb <= pwdata[7:0];        // R15
      if (hit_kp) keep <= pwdata[7:0];        // R09
    end
  end

  // Watchdog control, frozen once locked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_en <= 1'b0;                          // R06
      wd_lock <= 1'b0;
      wd_to <= posrc_pkg::WDTO_RST;
    end else if (wr_wd & ~wd_lock) begin      // R06
      wd_en <= pwdata[posrc_pkg::F_WD_EN];
      wd_lock <= pwdata[posrc_pkg::F_WD_LOCK];
      wd_to <= pwdata[posrc_pkg::F_WD_TO +: 8];
    end
  end

  // One-second enable pulse
  wire tick = tick_cnt == 27'(TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt <= 27'h0;
    else tick_cnt <= tick ? 27'h0 : tick_cnt + 27'h1;
  end

  // Long-press timer on the button
  wire lp_hit = lp_sec >= 4'(LONG_PRESS_S);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lp_sec <= 4'h0;
    else if (pin_s[0]) lp_sec <= 4'h0;        // Released
    else if (tick & ~lp_hit) lp_sec <= lp_sec + 4'h1;
  end

  // Watchdog second counter, kick restarts it
  wire wd_fire = wd_en & tick & (wd_sec == wd_to);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_sec <= 8'h0;
    else if (~wd_en | wd_kick | wd_fire) wd_sec <= 8'h0;
    else if (tick) wd_sec <= wd_sec + 8'h1;
  end

  // OFF sources in index order
  wire [6:0] src = {adc_threshold_off_event, supply_low_event, software_reset_bit,
                    thermal_event, wd_fire, pin_s[1], lp_hit};
  wire off_hold = |src;                       // Any request still on
  wire on_keep  = sw_on | pin_s[2];
  wire keep_fall = keep_d & ~on_keep;         // R07
  wire live = state == posrc_pkg::S_ACTIVE
            | state == posrc_pkg::S_SLEEP;
  wire imm  = |(pend & ~posrc_pkg::DELAYED_MASK) | keep_rel;
  wire dly_any = |(pend & posrc_pkg::DELAYED_MASK);
  wire dly_done = dly_run & (dly_left == 3'h0);
  wire go_off = live & (imm | dly_done);      // R16
  // Shutdown wins if any pending source asks for it
  wire cold = ~keep_rel & (|pend) & ((pend & ~rsel) == 7'h0); // R03
  wire hw_lvl = |(pend & rlvl);               // R02
  wire sleep_act = slp_pol ? pin_s[3] : ~pin_s[3]; // R18
  wire sleep_req = sleep_act & slp_unmask & ~irq_pending; // R10
  wire wake = irq_pending | ~(sleep_act & slp_unmask); // R11
  wire seq_done = seq_cnt == 5'(posrc_pkg::SEQ_CYCLES - 1);
  wire up_start = state == posrc_pkg::S_OFF & next_state != state;

  // Pending requests latched until acted on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 7'h0;
      keep_d <= 1'b0;
      keep_rel <= 1'b0;
    end else begin
      // A source arriving in the clearing cycle is kept: set wins
      pend <= ((go_off | up_start) ? 7'h0 : pend) | src;
      keep_d <= on_keep;
      keep_rel <= ((go_off | up_start) ? 1'b0 : keep_rel)
                | (keep_fall & live); // R07
    end
  end

  // Shared switch-off delay counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_run <= 1'b0;
      dly_left <= 3'h0;
    end else if (go_off | ~live) begin
      dly_run <= 1'b0;
    end else if (dly_any & ~dly_run) begin
      dly_run <= 1'b1;
      dly_left <= posrc_pkg::DLY_SEC[dly_code]; // R01
    end else if (dly_run & tick & (dly_left != 3'h0)) begin
      dly_left <= dly_left - 3'h1;
    end
  end

  // Next state of the power controller
  always_comb begin
    next_state = state;
    case (state)
      posrc_pkg::S_OFF: begin
        if (~off_hold & ~on_gate & (cold_pend | on_request)) begin
          next_state = posrc_pkg::S_OFF_TO_ACTIVE_SEQ;  // R05 R17
        end
      end
      posrc_pkg::S_OFF_TO_ACTIVE_SEQ: begin
        if (seq_done) next_state = posrc_pkg::S_ACTIVE;
      end
      posrc_pkg::S_ACTIVE: begin
        if (go_off) next_state = posrc_pkg::S_ACTIVE_TO_OFF_SEQ; // R16 R04
        else if (sleep_req) next_state = posrc_pkg::S_ACTIVE_TO_SLEEP_SEQ; // R08
      end
      posrc_pkg::S_ACTIVE_TO_SLEEP_SEQ: begin
        if (seq_done) next_state = posrc_pkg::S_SLEEP;
      end
      posrc_pkg::S_SLEEP: begin
        if (go_off) next_state = posrc_pkg::S_SLEEP_TO_OFF_SEQ; // R12 R04
        else if (wake) next_state = posrc_pkg::S_SLEEP_TO_ACTIVE_SEQ; // R11 R12
      end
      posrc_pkg::S_SLEEP_TO_ACTIVE_SEQ: begin
        if (seq_done) next_state = posrc_pkg::S_ACTIVE;
      end
      default: begin
        if (seq_done) next_state = posrc_pkg::S_OFF; // R04
      end
    endcase
  end

  // State, sequence step counter and restart flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= posrc_pkg::S_OFF;
      seq_cnt <= 5'h0;
      cold_pend <= 1'b0;
    end else begin
      state <= next_state;
      seq_cnt <= (next_state != state) ? 5'h0 : seq_cnt + 5'h1;
      if (go_off) cold_pend <= cold;          // R05
      else if (state == posrc_pkg::S_OFF) cold_pend <= 1'b0;
    end
  end

  // Reset level pulse at the start of an off sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_reset_pulse <= 1'b0;
      sw_reset_pulse <= 1'b0;
    end else begin
      hw_reset_pulse <= go_off & hw_lvl;      // R02
      sw_reset_pulse <= go_off & ~hw_lvl;     // R02
    end
  end

  // Resource modes: enables act at once, sleep pin via state
  wire powered = live | state == posrc_pkg::S_ACTIVE_TO_SLEEP_SEQ
               | state == posrc_pkg::S_SLEEP_TO_ACTIVE_SEQ;
  wire seq_slp = state == posrc_pkg::S_SLEEP;  // R13
  wire [7:0] stay = ~(aslp | aena | aenb)
                  | (aena & {8{pin_s[4]}})     // R14
                  | (aenb & {8{pin_s[5]}})     // R14
                  | (aslp & {8{~seq_slp}});    // R13
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) res_on <= 8'h0;
    else res_on <= powered ? (stay | keep) : 8'h0; // R09 R15
  end

  assign power_state = state;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_delay_wait: assert property ( // R01
    (dly_run && dly_left != 3'h0 && !imm && live) |=>
      state != posrc_pkg::S_ACTIVE_TO_OFF_SEQ && state != posrc_pkg::S_SLEEP_TO_OFF_SEQ)
    else $error("off before delay end");
  a_level_one: assert property ( // R02
    go_off |=> (hw_reset_pulse ^ sw_reset_pulse))
    else $error("no single reset level pulse");
  a_shut_stays: assert property ( // R04
    (state == posrc_pkg::S_ACTIVE_TO_OFF_SEQ && seq_done && !cold_pend) |=>
      state == posrc_pkg::S_OFF ##1
      (state == posrc_pkg::S_OFF || $past(on_request)))
    else $error("shutdown left off");
  a_cold_gated: assert property ( // R05
    (state == posrc_pkg::S_OFF && on_gate) |=> state == posrc_pkg::S_OFF)
    else $error("restart despite gating");
  a_wd_locked: assert property ( // R06
    (wr_wd && wd_lock) |=> $stable(wd_en) && $stable(wd_to))
    else $error("locked watchdog changed");
  a_irq_block: assert property ( // R10
    (state == posrc_pkg::S_ACTIVE && irq_pending) |=>
      state != posrc_pkg::S_ACTIVE_TO_SLEEP_SEQ)
    else $error("sleep with pending irq");
  a_wake_only: assert property ( // R12
    (state != posrc_pkg::S_SLEEP && state != posrc_pkg::S_SLEEP_TO_ACTIVE_SEQ) |=>
      state != posrc_pkg::S_SLEEP_TO_ACTIVE_SEQ)
    else $error("wake outside sleep");
  a_off_first: assert property ( // R16
    (state == posrc_pkg::S_ACTIVE && go_off) |=>
      state == posrc_pkg::S_ACTIVE_TO_OFF_SEQ)
    else $error("off request lost");
  a_on_after: assert property ( // R17
    (state == posrc_pkg::S_OFF && off_hold) |=> state == posrc_pkg::S_OFF)
    else $error("on while off held");
  a_seq_res: assert property ( // R13
    (state == posrc_pkg::S_ACTIVE && $past(state) == posrc_pkg::S_ACTIVE)
      |=> res_on == (res_on | $past(aslp)))
    else $error("sleep pin resource off");

endmodule

// ### verif/posrc_host.sv
// Host and push-button model driving the controller's control pins.
// Assumes a free-running pclk; pins change just after rising edges.
`timescale 1ns/1ns
module posrc_host (
  input  wire logic pclk,               // System clock
  output logic      power_button_pin_n, // Button, low pressed
  output logic      power_down_pin,     // Power-down request
  output logic      hold_on_pin,        // Keep device on
  output logic      sleep_control_pin,  // Sleep request, low
  output logic      direct_enable_a,    // Enable A
  output logic      direct_enable_b     // Enable B
);
  logic [5:0] pins;                     // Levels, button first
  assign {power_button_pin_n, power_down_pin, hold_on_pin,
          sleep_control_pin, direct_enable_a, direct_enable_b} = pins;
  // Idle: button released, hold on, no sleep request
  initial begin
    pins = 6'h2c;
  end
  // One pin changes right after a rising edge
  task automatic set_pin(input int i, input logic v);
    @(posedge pclk);
    pins[i] <= v;
  endtask
endmodule

// ### verif/posrc_top_test.sv
// Self-checking bench for the power-off and sleep request controller.
// Assumes posrc_pkg and posrc_top compiled first; short second tick.
`timescale 1ns/1ns
module posrc_top_test;
  logic        pclk, presetn;            // Clock and reset
  logic        psel, penable, pwrite;    // APB controls
  logic [7:0]  paddr;                    // APB address
  logic [31:0] pwdata, prdata, q;        // APB data
  logic        pready, pslverr, e;       // APB answer
  logic        pb_n, pd, hold, slp;      // Host pins
  logic        ena, enb;                 // Enable pins
  logic        therm, vlow, adc, irq;    // Events
  logic        on_req, gate;             // ON request and gate
  logic [2:0]  st;                       // Power state
  logic        hwp, swp;                 // Reset pulses
  logic [7:0]  res_on;                   // Resource on mask
  logic        hw_seen, sw_seen;         // Sticky pulse flags
  int          fails = 0;                // Mismatches
  int          n_checks = 0;             // Comparisons
  posrc_host host (.pclk(pclk), .power_button_pin_n(pb_n),
    .power_down_pin(pd), .hold_on_pin(hold), .sleep_control_pin(slp),
    .direct_enable_a(ena), .direct_enable_b(enb));
  posrc_top #(.TICK_CYCLES(20), .LONG_PRESS_S(1)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_button_pin_n(pb_n), .power_down_pin(pd),
    .hold_on_pin(hold), .sleep_control_pin(slp), .direct_enable_a(ena),
    .direct_enable_b(enb), .thermal_event(therm),
    .supply_low_event(vlow), .adc_threshold_off_event(adc),
    .irq_pending(irq), .on_request(on_req), .on_gate(gate),
    .power_state(st), .hw_reset_pulse(hwp), .sw_reset_pulse(swp),
    .res_on(res_on));
  // Clock, 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Catch one-cycle reset pulses
  always @(posedge pclk) begin
    if (hwp === 1'b1) hw_seen <= 1'b1;
    if (swp === 1'b1) sw_seen <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic wait_st(input logic [2:0] s, input int max);
    int n;
    n = 0;
    while (st !== s && n < max) begin
      @(posedge pclk);
      n++;
    end
    // One more edge so registered outputs follow the new state
    @(posedge pclk);
    chk({29'h0, st}, {29'h0, s});
  endtask
  task automatic power_on;
    on_req <= 1'b1;
    wait_st(posrc_pkg::S_ACTIVE, 200);
    on_req <= 1'b0;
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    summarize();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {therm, vlow, adc, irq, on_req, gate, hw_seen, sw_seen} = '0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(posrc_pkg::A_RSEL, {25'h0, posrc_pkg::RSEL_RST});
    rd(posrc_pkg::A_RLVL, {25'h0, posrc_pkg::RLVL_RST});
    rd(posrc_pkg::A_WDG, {16'h0, posrc_pkg::WDTO_RST, 8'h0});
    apb(1'b1, posrc_pkg::A_WDG, 32'h1002);
    apb(1'b1, posrc_pkg::A_WDG, 32'h2001);
    rd(posrc_pkg::A_WDG, 32'h1002);
    rd(8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("Test registers done");
    power_on();
    chk({24'h0, res_on}, 32'hff);
    apb(1'b1, posrc_pkg::A_ASLP, 32'h0f);
    apb(1'b1, posrc_pkg::A_AENA, 32'hf0);
    apb(1'b1, posrc_pkg::A_KEEP, 32'h03);
    apb(1'b1, posrc_pkg::A_CFG, 32'h18);
    chk({24'h0, res_on}, 32'h0f);
    irq <= 1'b1;
    host.set_pin(2, 1'b0);
    repeat (80) @(posedge pclk);
    chk({29'h0, st}, {29'h0, posrc_pkg::S_ACTIVE});
    irq <= 1'b0;
    wait_st(posrc_pkg::S_SLEEP, 200);
    chk({24'h0, res_on}, 32'h03);
    host.set_pin(1, 1'b1);
    repeat (4) @(posedge pclk);
    chk({24'h0, res_on}, 32'hf3);
    host.set_pin(1, 1'b0);
    host.set_pin(2, 1'b1);
    wait_st(posrc_pkg::S_SLEEP_TO_ACTIVE_SEQ, 10);
    chk({24'h0, res_on}, 32'h0f);
    wait_st(posrc_pkg::S_ACTIVE, 100);
    $display("Test sleep and wake done");
    apb(1'b1, posrc_pkg::A_CFG, 32'h1c);
    wait_st(posrc_pkg::S_ACTIVE_TO_SLEEP_SEQ, 10);
    apb(1'b1, posrc_pkg::A_CFG, 32'h10);
    wait_st(posrc_pkg::S_ACTIVE, 100);
    therm <= 1'b1;
    @(posedge pclk);
    therm <= 1'b0;
    wait_st(posrc_pkg::S_ACTIVE_TO_OFF_SEQ, 10);
    repeat (2) @(posedge pclk);
    chk({31'h0, hw_seen}, 32'h1);
    wait_st(posrc_pkg::S_OFF, 60);
    repeat (80) @(posedge pclk);
    chk({29'h0, st}, {29'h0, posrc_pkg::S_OFF});
    {gate, on_req} <= 2'b11;
    repeat (40) @(posedge pclk);
    chk({29'h0, st}, {29'h0, posrc_pkg::S_OFF});
    gate <= 1'b0;
    $display("Test thermal shutdown done");
    power_on();
    apb(1'b1, posrc_pkg::A_CFG, 32'h1a);
    apb(1'b1, posrc_pkg::A_RSEL, 32'h02);
    host.set_pin(4, 1'b1);
    repeat (15) @(posedge pclk);
    chk({29'h0, st}, {29'h0, posrc_pkg::S_ACTIVE});
    wait_st(posrc_pkg::S_ACTIVE_TO_OFF_SEQ, 80);
    host.set_pin(4, 1'b0);
    wait_st(posrc_pkg::S_OFF_TO_ACTIVE_SEQ, 80);
    wait_st(posrc_pkg::S_ACTIVE, 80);
    $display("Test delayed cold restart done");
    apb(1'b1, posrc_pkg::A_RLVL, 32'h6f);
    {hw_seen, sw_seen} = 2'b00;
    apb(1'b1, posrc_pkg::A_CFG, 32'h30);
    wait_st(posrc_pkg::S_ACTIVE_TO_OFF_SEQ, 10);
    repeat (2) @(posedge pclk);
    chk({30'h0, hw_seen, sw_seen}, 32'h1);
    wait_st(posrc_pkg::S_OFF, 60);
    power_on();
    apb(1'b1, posrc_pkg::A_CFG, 32'h0);
    repeat (20) @(posedge pclk);
    chk({29'h0, st}, {29'h0, posrc_pkg::S_ACTIVE});
    host.set_pin(3, 1'b0);
    wait_st(posrc_pkg::S_ACTIVE_TO_OFF_SEQ, 10);
    $display("Test software off done");
    summarize();
  end
endmodule
